//--- hdl/page_table_read.sv
// Execution unit for the paged program-memory table read instruction
`timescale 1ns/10ps
//
// Operation
// RULE1: Opcode top bits 0010 selects table read
// RULE2: Page operand must lie in implemented memory
// RULE3: Address is page, D2..D0 and A3..A0
// RULE4: Word bits 7..4 to B, 3..0 to A
// RULE5: Flag set: bits 9,8 to D1,D0, D2 cleared
// RULE6: Push program counter on stack first
// RULE7: Restore counter from stack, then pop once
// RULE8: Software keeps one stack level free
// RULE9: One word, three cycles, carry and skip untouched
module page_table_read
	import table_read_pkg::*;
(
	input wire logic mclk, // System clock, 20 MHz
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic instr_valid, // New instruction word presented
	input wire logic [WORD_W-1:0] instr_word, // Instruction word
	input wire logic upper_bits_transfer_flag, // Load D from word bits 9..8
	input wire logic [PC_W-1:0] pc_in, // Counter of the next instruction
	input wire logic [3:0] acc_in, // Accumulator contents
	input wire logic [2:0] d_in, // Register D contents
	input wire logic [WORD_W-1:0] rom_data, // Program memory word, one clock after address
	output logic [PC_W-1:0] rom_addr, // Program memory address
	output logic rom_re, // Program memory read strobe
	output logic [PAGE_W-1:0] pc_high_part, // Counter page part
	output logic [LOW_W-1:0] pc_low_part, // Counter position part
	output logic pc_we, // Counter update strobe
	output logic [3:0] acc_out, // New accumulator value
	output logic acc_we, // Accumulator write strobe
	output logic [3:0] b_out, // New register B value
	output logic b_we, // Register B write strobe
	output logic [2:0] register_d_bits, // New register D value
	output logic d_we, // Register D write strobe
	output logic [STACK_IDX_W-1:0] stack_index, // Return stack index
	output logic busy, // Instruction in progress
	output logic done // Instruction finished
);
	exec_state_t state_q, state_d;
	logic [3:0] div_q, div_d;
	logic [1:0] cyc_q, cyc_d;
	logic [PAGE_W-1:0] pch_q, pch_d;
	logic [LOW_W-1:0] pcl_q, pcl_d;
	logic [STACK_IDX_W-1:0] sp_q, sp_d;
	logic [3:0] acc_q, acc_d;
	logic [3:0] b_q, b_d;
	logic [2:0] dr_q, dr_d;
	logic [PC_W-1:0] rom_addr_q, rom_addr_d;
	logic rom_re_q, rom_re_d;
	logic pc_we_q, pc_we_d;
	logic acc_we_q, acc_we_d;
	logic b_we_q, b_we_d;
	logic d_we_q, d_we_d;
	logic done_q, done_d;
	logic upper_bits_transfer_flag_q, upper_bits_transfer_flag_d;
	logic [2:0] dsrc_q, dsrc_d;
	logic [3:0] asrc_q, asrc_d;
	logic [PC_W-1:0] pcsave_q, pcsave_d;
	logic push_en;
	logic [PC_W-1:0] stack_rd;
	logic mcyc_en;
	logic is_table_read;

	// Decode looks only at the opcode field; the operand is the page
	assign is_table_read = instr_word[OPCODE_MSB:OPCODE_LSB] == TABLE_READ_OPCODE; // RULE1
	assign mcyc_en = div_q == MACHINE_CYCLE_CLKS - 4'h1;
	// The start edge is clock 0 of the first machine cycle, so the save clock sees a count of 1
	assign push_en = state_q == ST_SAVE && cyc_q == 2'h0 && div_q == 4'h1; // RULE6

	return_stack_mem u_stack (
		.mclk(mclk),
		.wr_en(push_en),
		.wr_idx(sp_q),
		.wr_data(pcsave_q),
		.rd_idx(sp_q),
		.rd_data(stack_rd)
	);

	// Machine cycle divider and sequencer; it runs only during the instruction
	always_comb begin
		state_d = state_q;
		div_d = div_q;
		cyc_d = cyc_q;
		pch_d = pch_q;
		pcl_d = pcl_q;
		sp_d = sp_q;
		acc_d = acc_q;
		b_d = b_q;
		dr_d = dr_q;
		rom_addr_d = rom_addr_q;
		rom_re_d = 1'b0;
		pc_we_d = 1'b0;
		acc_we_d = 1'b0;
		b_we_d = 1'b0;
		d_we_d = 1'b0;
		done_d = 1'b0;
		upper_bits_transfer_flag_d = upper_bits_transfer_flag_q;
		dsrc_d = dsrc_q;
		asrc_d = asrc_q;
		pcsave_d = pcsave_q;
		if (state_q != ST_IDLE) begin
			div_d = mcyc_en ? 4'h0 : div_q + 4'h1;
		end
		case (state_q)
			ST_IDLE: begin
				div_d = 4'h0;
				cyc_d = 2'h0;
				if (instr_valid && is_table_read) begin
					// Operands are captured now so later core activity cannot disturb them
					state_d = ST_SAVE;
					div_d = 4'h1; // RULE9
					pch_d = {1'b0, instr_word[OPERAND_MSB:0]}; // RULE2
					upper_bits_transfer_flag_d = upper_bits_transfer_flag;
					dsrc_d = d_in;
					asrc_d = acc_in;
					pcsave_d = pc_in;
					sp_d = sp_q + 3'h1; // RULE6
				end
			end
			ST_SAVE: begin
				// Stack write happens on the first clock, redirect after it
				if (mcyc_en) begin
					pcl_d = {dsrc_q, asrc_q}; // RULE3
					rom_addr_d = {pch_q, dsrc_q, asrc_q}; // RULE3
					rom_re_d = 1'b1;
					pc_we_d = 1'b1;
					cyc_d = cyc_q + 2'h1;
					state_d = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (mcyc_en) begin
					b_d = rom_data[7:4]; // RULE4
					acc_d = rom_data[3:0]; // RULE4
					b_we_d = 1'b1;
					acc_we_d = 1'b1;
					if (upper_bits_transfer_flag_q) begin
						dr_d = {1'b0, rom_data[9:8]}; // RULE5
						d_we_d = 1'b1; // RULE5
					end
					cyc_d = cyc_q + 2'h1;
					state_d = ST_RESTORE;
				end
			end
			ST_RESTORE: begin
				// Third machine cycle ends the instruction; carry has no port here
				if (mcyc_en && cyc_q == OP_CYCLES - 2'h1) begin // RULE9
					pch_d = stack_rd[PC_W-1:LOW_W]; // RULE7
					pcl_d = stack_rd[LOW_W-1:0]; // RULE7
					pc_we_d = 1'b1;
					sp_d = sp_q - 3'h1; // RULE7
					done_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// State registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			div_q <= 4'h0;
			cyc_q <= 2'h0;
			pch_q <= '0;
			pcl_q <= '0;
			sp_q <= STACK_IDX_RESET;
			acc_q <= NIBBLE_RESET;
			b_q <= NIBBLE_RESET;
			dr_q <= DREG_RESET;
			rom_addr_q <= '0;
			rom_re_q <= 1'b0;
			pc_we_q <= 1'b0;
			acc_we_q <= 1'b0;
			b_we_q <= 1'b0;
			d_we_q <= 1'b0;
			done_q <= 1'b0;
			upper_bits_transfer_flag_q <= 1'b0;
			dsrc_q <= DREG_RESET;
			asrc_q <= NIBBLE_RESET;
			pcsave_q <= '0;
		end else begin
			state_q <= state_d;
			div_q <= div_d;
			cyc_q <= cyc_d;
			pch_q <= pch_d;
			pcl_q <= pcl_d;
			sp_q <= sp_d;
			acc_q <= acc_d;
			b_q <= b_d;
			dr_q <= dr_d;
			rom_addr_q <= rom_addr_d;
			rom_re_q <= rom_re_d;
			pc_we_q <= pc_we_d;
			acc_we_q <= acc_we_d;
			b_we_q <= b_we_d;
			d_we_q <= d_we_d;
			done_q <= done_d;
			upper_bits_transfer_flag_q <= upper_bits_transfer_flag_d;
			dsrc_q <= dsrc_d;
			asrc_q <= asrc_d;
			pcsave_q <= pcsave_d;
		end
	end

	// Outputs straight from flip-flops; busy is combinational handshake
	assign rom_addr = rom_addr_q;
	assign rom_re = rom_re_q;
	assign pc_high_part = pch_q;
	assign pc_low_part = pcl_q;
	assign pc_we = pc_we_q;
	assign acc_out = acc_q;
	assign acc_we = acc_we_q;
	assign b_out = b_q;
	assign b_we = b_we_q;
	assign register_d_bits = dr_q;
	assign d_we = d_we_q;
	assign stack_index = sp_q;
	assign busy = state_q != ST_IDLE;
	assign done = done_q;
endmodule // page_table_read

//--- hdl/table_read_pkg.sv
// Constants and types for the paged program-memory table read unit
package table_read_pkg;
	localparam int WORD_W = 10; // Instruction and program memory word width
	localparam int PAGE_W = 7; // Page part of the program counter
	localparam int LOW_W = 7; // Position part of the program counter
	localparam int PC_W = PAGE_W + LOW_W;
	localparam int STACK_DEPTH = 8; // Return stack levels
	localparam int STACK_IDX_W = 3;
	localparam logic [3:0] TABLE_READ_OPCODE = 4'h2; // Top four bits 0010
	localparam int OPCODE_MSB = 9;
	localparam int OPCODE_LSB = 6;
	localparam int OPERAND_MSB = 5;
	localparam logic [3:0] MACHINE_CYCLE_CLKS = 4'h4; // mclk periods per machine cycle
	localparam logic [1:0] OP_CYCLES = 2'h3; // Machine cycles per table read
	localparam logic [3:0] NIBBLE_RESET = 4'h0;
	localparam logic [2:0] DREG_RESET = 3'h0;
	localparam logic [STACK_IDX_W-1:0] STACK_IDX_RESET = 3'h7; // First push lands on level 0

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAVE = 2'b01,
		ST_FETCH = 2'b11,
		ST_RESTORE = 2'b10
	} exec_state_t;
endpackage

//--- hdl/return_stack_mem.sv
// Return stack storage with one write port and a registered read port
`timescale 1ns/10ps
module return_stack_mem
	import table_read_pkg::*;
(
	input wire logic mclk, // System clock
	input wire logic wr_en, // Write strobe
	input wire logic [STACK_IDX_W-1:0] wr_idx, // Level written
	input wire logic [PC_W-1:0] wr_data, // Saved program counter
	input wire logic [STACK_IDX_W-1:0] rd_idx, // Level read
	output logic [PC_W-1:0] rd_data // Registered read data
);
	logic [PC_W-1:0] mem_q [STACK_DEPTH];
	logic [PC_W-1:0] rd_data_q;

	// Storage needs no reset; software never reads an unwritten level
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem_q[wr_idx] <= wr_data;
		end
		rd_data_q <= mem_q[rd_idx];
	end

	assign rd_data = rd_data_q;
endmodule // return_stack_mem

//--- verification/table_read_checker_assertions.sv
// Concurrent checks on the ports of the paged table read unit
`timescale 1ns/10ps
module table_read_checker
	import table_read_pkg::*;
(
	input logic mclk, reset_n, instr_valid, upper_bits_transfer_flag, // Control
	input logic [WORD_W-1:0] instr_word, rom_data, // Words
	input logic [PC_W-1:0] pc_in, rom_addr, // Counters
	input logic [3:0] acc_in, acc_out, b_out, // Nibbles
	input logic [2:0] d_in, register_d_bits, // Register D
	input logic [PAGE_W-1:0] pc_high_part, // Page part
	input logic [LOW_W-1:0] pc_low_part, // Position part
	input logic [STACK_IDX_W-1:0] stack_index, // Stack index
	input logic rom_re, pc_we, acc_we, b_we, d_we, busy, done // Strobes
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Accepted table read request
	sequence s_start;
		!busy && instr_valid && instr_word[OPCODE_MSB:OPCODE_LSB] == TABLE_READ_OPCODE;
	endsequence
	// Busy for the rest of three machine cycles, then free for the next word
	sequence s_run;
		busy[*8] ##1 busy[*3] ##1 !busy;
	endsequence
	AST_PUSH: assert property (s_start |=> stack_index == $past(stack_index) + 3'h1)
		else $error("stack index not advanced");
	AST_IGNORE: assert property (!busy && instr_valid &&
		instr_word[OPCODE_MSB:OPCODE_LSB] != TABLE_READ_OPCODE |=> !busy)
		else $error("foreign opcode started");
	AST_ADDR: assert property (s_start |-> ##4 rom_re && rom_addr == {1'b0,
		$past(instr_word[OPERAND_MSB:0], 4), $past(d_in, 4), $past(acc_in, 4)})
		else $error("bad table address");
	AST_JUMP: assert property (s_start |-> ##4 pc_we && {pc_high_part, pc_low_part} == rom_addr)
		else $error("counter not redirected");
	AST_NIBBLES: assert property (rom_re |-> ##4 acc_we && b_we &&
		acc_out == $past(rom_data[3:0]) && b_out == $past(rom_data[7:4]))
		else $error("bad accumulator or B load");
	AST_DREG_ON: assert property (s_start ##0 upper_bits_transfer_flag |-> ##8 d_we &&
		register_d_bits == {1'b0, $past(rom_data[9:8])})
		else $error("bad D load");
	AST_DREG_OFF: assert property (s_start ##0 !upper_bits_transfer_flag |-> ##8 !d_we)
		else $error("D written with flag clear");
	AST_RESTORE: assert property (s_start |-> ##12 done && pc_we &&
		{pc_high_part, pc_low_part} == $past(pc_in, 12) && stack_index == $past(stack_index, 12))
		else $error("counter or stack not restored");
	AST_TIMING: assert property (s_start |=> s_run)
		else $error("wrong instruction length");
endmodule // table_read_checker

bind page_table_read table_read_checker u_chk (.*);

//--- verification/rom_model.sv
// Program memory model answering table reads
`timescale 1ns/10ps
module rom_model
	import table_read_pkg::*;
(
	input wire logic mclk, // System clock
	input wire logic rom_re, // Read strobe
	input wire logic [PC_W-1:0] rom_addr, // Read address
	output logic [WORD_W-1:0] rom_data // Word, held three clocks after the strobe
);
	logic [WORD_W-1:0] word_q = 10'h155;
	logic [1:0] hold_q = 2'h0;
	// Contents are a fixed hash of the address so every page gives distinct words
	always @(posedge mclk) begin
		if (rom_re) begin
			word_q <= rom_addr[9:0] ^ {rom_addr[13:7], 3'h5};
			hold_q <= 2'h3;
		end else if (hold_q != 2'h0) begin
			hold_q <= hold_q - 2'h1;
		end
	end
	// Past the hold time the bus shows the inverse, so a late sample cannot pass
	assign rom_data = (hold_q != 2'h0) ? word_q : ~word_q;
endmodule // rom_model

//--- verification/test_page_table_read.sv
// Self-checking bench for the paged table read unit
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end
module test_page_table_read
	import table_read_pkg::*;
;
	typedef struct {logic [WORD_W-1:0] word; logic load_d; logic [PC_W-1:0] pc;} exp_t;
	logic mclk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, upper_bits_transfer_flag = 1'b0;
	logic [WORD_W-1:0] instr_word = '0, rom_data;
	logic [PC_W-1:0] pc_in = '0, rom_addr;
	logic [3:0] acc_in = '0, acc_out, b_out, seen_d;
	logic [2:0] d_in = '0, register_d_bits;
	logic [PAGE_W-1:0] pc_high_part;
	logic [LOW_W-1:0] pc_low_part;
	logic [STACK_IDX_W-1:0] stack_index;
	logic rom_re, pc_we, acc_we, b_we, d_we, busy, done;
	logic [7:0] seen_ab;
	logic [15:0] seed = 16'h4b94;
	exp_t exp_q[$];
	exp_t got_e;
	int fail_count = 0, compares = 0;

	page_table_read u_dut (.*);
	rom_model u_rom (.mclk, .rom_re, .rom_addr, .rom_data);
	initial begin forever #25 mclk = ~mclk; end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic summarize();
		$display("Counts: %0d compares, %0d mismatches", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// One request, then for a table read junk with valid often high while busy, which must be ignored
	task automatic issue(input logic [3:0] opc);
		exp_t e;
		logic [PC_W-1:0] a;
		seed = lfsr(seed);
		a = {1'b0, seed[5:0], seed[8:6], seed[12:9]};
		instr_valid <= 1'b1;
		instr_word <= {opc, seed[5:0]};
		d_in <= seed[8:6];
		acc_in <= seed[12:9];
		upper_bits_transfer_flag <= seed[13];
		pc_in <= seed[15:2];
		e.word = a[9:0] ^ {a[13:7], 3'h5};
		e.load_d = seed[13];
		e.pc = seed[15:2];
		if (opc == TABLE_READ_OPCODE) exp_q.push_back(e);
		@(posedge mclk);
		repeat ((opc == TABLE_READ_OPCODE) ? 11 : 0) begin
			seed = lfsr(seed);
			instr_word <= seed[9:0];
			instr_valid <= seed[10];
			@(posedge mclk);
		end
	endtask

	// Collect the data strobes, judge the whole instruction when it finishes
	always @(posedge mclk) begin
		if (acc_we) begin
			seen_ab = {b_out, acc_out};
			seen_d = d_we ? {1'b1, register_d_bits} : 4'h0;
		end
		if (done) begin
			if (exp_q.size() == 0) begin
				`CHK(1'b1, 1'b0)
			end else begin
				got_e = exp_q.pop_front();
				`CHK(seen_ab, got_e.word[7:0])
				`CHK(seen_d, got_e.load_d ? {2'b10, got_e.word[9:8]} : 4'h0)
				`CHK({pc_high_part, pc_low_part}, got_e.pc)
				`CHK(stack_index, STACK_IDX_RESET)
				seen_ab = 'x;
			end
		end
	end

	initial begin
		#200000;
		fail_count++;
		summarize();
	end

	// Back-to-back requests; one in flight borrows a single stack level
	initial begin
		repeat (6) @(posedge mclk);
		`CHK(stack_index, STACK_IDX_RESET)
		`CHK(busy, 1'b0)
		reset_n <= 1'b1;
		$display("Reset test finished");
		for (int i = 0; i < 40; i++) begin
			issue((i % 4 == 3) ? seed[15:12] : TABLE_READ_OPCODE);
		end
		instr_valid <= 1'b0;
		repeat (16) @(posedge mclk);
		`CHK(exp_q.size(), 0)
		$display("Random table read test finished");
		summarize();
	end
endmodule // test_page_table_read
